// File: dsb_pkg.sv
// constants for the data-side bus slave
package dsb_pkg;
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 64;
  localparam int BE_W        = 8;
  localparam int WIDX_W      = 3;
  localparam int PRIO_W      = 2;
  localparam int WADDR_W     = 30;
  localparam int LINE_LSB    = 5;
  localparam int WORD_LSB    = 2;
  localparam int DW_LSB      = 3;
  localparam int QUEUE_DEPTH = 3;
  // queued request layout
  localparam int ENT_BE_LSB  = 0;
  localparam int ENT_WA_LSB  = 8;
  localparam int ENT_LINE    = 38;
  localparam int ENT_RNW     = 39;
  localparam int ENT_W       = 40;
  localparam logic [3:0] BEATS_DW   = 4'h4;
  localparam logic [3:0] BEATS_WORD = 4'h8;
  localparam logic [3:0] BEATS_ONE  = 4'h1;
  typedef enum logic [2:0] {
    DSB_IDLE  = 3'b001,
    DSB_READ  = 3'b010,
    DSB_WRITE = 3'b100
  } dsb_state_t;
endpackage

// File: dsb_queue_if.sv
// request queue carrier between slave engine and its queue
`timescale 1ns/100ps
interface dsb_queue_if #(parameter int W = 40);
  logic         push;
  logic [W-1:0] push_data;
  logic         pop;
  logic [W-1:0] head;
  logic         empty;
  logic         full;
  modport queue (input push, input push_data, input pop,
                 output head, output empty, output full);
  modport user (output push, output push_data, output pop,
                input head, input empty, input full);
endinterface

// File: dsb_queue.sv
// in-order request queue, register based
`timescale 1ns/100ps
module dsb_queue #(
  parameter int W     = 40,
  parameter int DEPTH = 3
) (
  input  wire logic  clk,
  input  wire logic  rst_b,
  input  wire logic  clk_en,
  dsb_queue_if.queue q
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          do_push;
  logic          do_pop;

  assign do_push = q.push && !q.full;
  assign do_pop  = q.pop && !q.empty;
  assign q.head  = mem_q[rp_q];
  assign q.empty = (cnt_q == '0);
  assign q.full  = (cnt_q == CW'(DEPTH));

  always_ff @(posedge clk) begin
    if (clk_en && do_push) begin
      mem_q[wp_q] <= q.push_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (do_push) begin
        wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : PW'(wp_q + 1'b1);
      end
      if (do_pop) begin
        rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : PW'(rp_q + 1'b1);
      end
      if (do_push && !do_pop) begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end else if (do_pop && !do_push) begin
        cnt_q <= CW'(cnt_q - 1'b1);
      end
    end
  end
endmodule // dsb_queue

// File: dsb_slave.sv
// data-side bus slave with local memory, serving the cache port
// Rules of the data-side bus, port side and slave side
// R01: port requests; slave acknowledges address.
// R02: port drops request after acknowledge.
// R03: slave captures qualifiers by acknowledge cycle.
// R04: qualifiers stable until after acknowledge.
// R05: direction high read, low write.
// R06: size high line, low single word.
// R07: line address bits select aligned line.
// R08: single word uses byte enables.
// R09: slave ignores byte enables on lines.
// R10: line is four doublewords or eight words.
// R11: any read order, word index each beat.
// R12: port drives two-bit request priority.
// R13: at most two reads, one write outstanding.
// R14: request low one cycle between requests.
// R15: slave services pipelined requests in order.
// R16: writes never pipelined, two-cycle gap.
// R17: abort only on reset, request dropped.
// R18: read acknowledge marks valid read data.
// R19: write acknowledge marks taken write data.
// R20: slave reports its bus width.
// R21: busy high while operation pending.
// R22: slave flags transfer faults with error.
// R23: cacheable qualifier follows storage attribute.
// R24: write-through qualifier valid when cacheable.
// R25: reset clears outputs and transfer state.
`timescale 1ns/100ps
module dsb_slave
  import dsb_pkg::*;
#(
  parameter bit WIDE64 = 1'b1,
  parameter int MEM_WORDS = 256
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  input  wire logic                dside_req_out,
  input  wire logic                dside_read_not_write,
  input  wire logic [ADDR_W-1:0]   dside_addr_out,
  input  wire logic                dside_line_size_sel,
  input  wire logic                dside_cacheable_attr,
  input  wire logic                dside_write_through_attr,
  input  wire logic                dside_user_attr,
  input  wire logic                dside_guarded_attr,
  input  wire logic [BE_W-1:0]     dside_byte_enables,
  input  wire logic [PRIO_W-1:0]   dside_req_priority,
  input  wire logic                dside_abort_out,
  input  wire logic [DATA_W-1:0]   dside_wr_data_bus,
  output logic                     dside_addr_ack_in,
  output logic                     dside_slave_width_in,
  output logic                     dside_rd_data_ack_in,
  output logic [DATA_W-1:0]        dside_rd_data_bus,
  output logic [WIDX_W-1:0]        dside_rd_word_index,
  output logic                     dside_wr_data_ack_in,
  output logic                     dside_slave_busy_in,
  output logic                     dside_slave_err_in,
  output logic [3:0]               last_attr_q
);
  localparam int IW = $clog2(MEM_WORDS);

  logic [31:0]        mem_q [MEM_WORDS];
  dsb_state_t         st_q;
  logic [ENT_W-1:0]   cur_q;
  logic [3:0]         beat_q;
  logic [3:0]         nbeats;
  logic [WIDX_W-1:0]  widx;
  logic [WADDR_W-1:0] wa;
  logic               bad;
  logic [IW-1:0]      mi;
  logic [WADDR_W-1:0] wr_wa_q;
  logic [BE_W-1:0]    wr_mask_q;
  logic               wr_bad_q;
  logic [BE_W-1:0]    cur_be;
  logic               last_beat;

  dsb_queue_if #(.W(ENT_W)) qi ();

  dsb_queue #(.W(ENT_W), .DEPTH(QUEUE_DEPTH)) u_queue (
    .clk    (clk),
    .rst_b  (rst_b),
    .clk_en (clk_en),
    .q      (qi.queue)
  );

  // R03 capture at end of ack cycle
  assign qi.push      = dside_addr_ack_in && dside_req_out;
  assign qi.push_data = {dside_read_not_write, dside_line_size_sel,
                         dside_addr_out[ADDR_W-1:WORD_LSB],
                         dside_byte_enables};
  // R15 next request only once current one is done
  assign qi.pop       = (st_q == DSB_IDLE) && !qi.empty;

  // R10 beat count from own width
  assign nbeats = !cur_q[ENT_LINE] ? BEATS_ONE :
                  (WIDE64 ? BEATS_DW : BEATS_WORD);
  assign last_beat = (beat_q == nbeats - 4'h1);
  // R09 byte enables dropped for lines
  assign cur_be = cur_q[ENT_LINE] ? {BE_W{1'b1}} : cur_q[ENT_BE_LSB +: BE_W];

  // R07 R11 reads start at target word, wrapping in line; line writes run from word 0
  always_comb begin
    widx = cur_q[ENT_WA_LSB +: WIDX_W];
    if (cur_q[ENT_LINE]) begin
      if (!cur_q[ENT_RNW]) begin
        widx = WIDE64 ? {beat_q[1:0], 1'b0} : beat_q[2:0];
      end else if (WIDE64) begin
        widx = {2'(widx[2:1] + beat_q[1:0]), 1'b0};
      end else begin
        widx = 3'(widx + beat_q[2:0]);
      end
    end else if (WIDE64) begin
      widx = {widx[2:1], 1'b0};
    end
    wa = {cur_q[ENT_WA_LSB + WIDX_W +: WADDR_W - WIDX_W], widx};
    mi = wa[IW-1:0];
    // R22 beyond local memory is a fault
    bad = (wa >> IW) != '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= DSB_IDLE;
      cur_q  <= '0;
      beat_q <= '0;
    end else if (clk_en) begin
      case (st_q)
        DSB_IDLE: begin
          if (!qi.empty) begin
            cur_q  <= qi.head;
            beat_q <= '0;
            st_q   <= qi.head[ENT_RNW] ? DSB_READ : DSB_WRITE;
          end
        end
        DSB_READ, DSB_WRITE: begin
          beat_q <= 4'(beat_q + 1'b1);
          if (last_beat) begin
            st_q <= DSB_IDLE;
          end
        end
        default: st_q <= DSB_IDLE;
      endcase
    end
  end

  // address acknowledge, one cycle after request seen
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dside_addr_ack_in    <= 1'b0;
      dside_slave_width_in <= 1'b0;
      last_attr_q          <= '0;
    end else if (clk_en) begin
      // R01 ack unless aborted or queue full
      dside_addr_ack_in <= dside_req_out && !dside_addr_ack_in &&
                           !dside_abort_out && !qi.full;
      // R20 width shown with the acknowledge
      dside_slave_width_in <= WIDE64 && dside_req_out &&
                              !dside_addr_ack_in && !dside_abort_out &&
                              !qi.full;
      if (qi.push) begin
        // R24 write-through kept only with cacheable
        last_attr_q <= {dside_cacheable_attr,
                        dside_write_through_attr && dside_cacheable_attr,
                        dside_user_attr, dside_guarded_attr};
      end
    end
  end

  // data beats; outputs are all registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dside_rd_data_ack_in <= 1'b0;
      dside_rd_data_bus    <= '0;
      dside_rd_word_index  <= '0;
      dside_wr_data_ack_in <= 1'b0;
      dside_slave_err_in   <= 1'b0;
      wr_wa_q              <= '0;
      wr_mask_q            <= '0;
      wr_bad_q             <= 1'b0;
    end else if (clk_en) begin
      // R18 read ack with valid data
      dside_rd_data_ack_in <= (st_q == DSB_READ);
      // R19 write ack when data taken
      dside_wr_data_ack_in <= (st_q == DSB_WRITE);
      // R22 error pulse with faulty beat
      dside_slave_err_in   <= (st_q != DSB_IDLE) && bad;
      if (st_q == DSB_READ) begin
        // R11 index names word on bus
        dside_rd_word_index <= widx;
        if (bad) begin
          dside_rd_data_bus <= '0;
        end else if (WIDE64) begin
          dside_rd_data_bus <= {mem_q[mi], mem_q[mi | IW'(1)]};
        end else begin
          // narrow slave repeats word on both halves
          dside_rd_data_bus <= {mem_q[mi], mem_q[mi]};
        end
      end else begin
        dside_rd_word_index <= '0;
      end
      if (st_q == DSB_WRITE) begin
        wr_wa_q  <= wa;
        wr_bad_q <= bad;
        // R08 narrow slave picks half by address
        if (WIDE64 || cur_q[ENT_LINE]) begin
          wr_mask_q <= cur_be;
        end else begin
          wr_mask_q <= cur_q[ENT_WA_LSB] ? {cur_be[3:0], 4'h0} :
                                           {cur_be[7:4], 4'h0};
        end
      end
    end
  end

  // write data lands in the ack cycle
  always_ff @(posedge clk) begin
    if (clk_en && dside_wr_data_ack_in && !wr_bad_q) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_mask_q[4 + b]) begin
          mem_q[wr_wa_q[IW-1:0]][8*b +: 8] <= dside_wr_data_bus[32+8*b +: 8];
        end
        if (WIDE64 && wr_mask_q[b]) begin
          mem_q[wr_wa_q[IW-1:0] | IW'(1)][8*b +: 8] <=
            dside_wr_data_bus[8*b +: 8];
        end
      end
    end
  end

  // R21 busy while anything is owed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dside_slave_busy_in <= 1'b0;
    end else if (clk_en) begin
      // held through the last data beat, the operation is not done yet
      dside_slave_busy_in <= qi.push || !qi.empty || (st_q != DSB_IDLE);
    end
  end
endmodule // dsb_slave

// File: dsb_slave_asserts.sv
// protocol checks on the bus slave ports
`timescale 1ns/100ps
module dsb_slave_asserts
  import dsb_pkg::*;
#(parameter bit WIDE64 = 1'b1) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              dside_req_out,
  input wire logic              dside_abort_out,
  input wire logic              dside_addr_ack_in,
  input wire logic              dside_slave_width_in,
  input wire logic              dside_rd_data_ack_in,
  input wire logic [WIDX_W-1:0] dside_rd_word_index,
  input wire logic              dside_wr_data_ack_in,
  input wire logic              dside_slave_busy_in,
  input wire logic              dside_slave_err_in
);
  logic dack;
  assign dack = dside_rd_data_ack_in | dside_wr_data_ack_in;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_has_req: assert property (dside_addr_ack_in |-> $past(dside_req_out))
    else $error("address ack without request");
  a_ack_bounded: assert property ($rose(dside_req_out) && !dside_abort_out
    |-> ##[1:60] dside_addr_ack_in) else $error("request never acked");
  a_width_ack: assert property (dside_slave_width_in ==
    (dside_addr_ack_in && WIDE64)) else $error("width not with ack");
  a_busy_after_ack: assert property (dside_addr_ack_in |=> dside_slave_busy_in)
    else $error("busy low after ack");
  a_busy_on_beat: assert property (dack |-> dside_slave_busy_in)
    else $error("busy low during a beat");
  a_first_beat: assert property (dside_addr_ack_in && !dside_slave_busy_in
    && !dack |-> ##[2:3] dack) else $error("first beat late");
  a_err_on_beat: assert property (dside_slave_err_in |-> dack)
    else $error("error outside a beat");
  a_dw_index: assert property (dside_rd_data_ack_in && WIDE64
    |-> !dside_rd_word_index[0]) else $error("odd doubleword index");
  a_beat_run: assert property ((dack && WIDE64) [*4] |=> !dack)
    else $error("beat run too long");
  c_line: cover property (dside_rd_data_ack_in [*4]);
  c_piped: cover property (dside_addr_ack_in && dside_slave_busy_in);
  c_fault: cover property (dside_slave_err_in);
endmodule // dsb_slave_asserts
bind dsb_slave dsb_slave_asserts #(.WIDE64(WIDE64)) dsb_slave_asserts_i (.*);

// File: dsb_port_model.sv
// behavioural cache-side port driving the bus slave
`timescale 1ns/100ps
module dsb_port_model
  import dsb_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  output logic              dside_req_out,
  output logic              dside_read_not_write,
  output logic [ADDR_W-1:0] dside_addr_out,
  output logic              dside_line_size_sel,
  output logic              dside_cacheable_attr,
  output logic              dside_write_through_attr,
  output logic              dside_user_attr,
  output logic              dside_guarded_attr,
  output logic [BE_W-1:0]   dside_byte_enables,
  output logic [PRIO_W-1:0] dside_req_priority,
  output logic              dside_abort_out,
  output logic [DATA_W-1:0] dside_wr_data_bus,
  input  wire logic         dside_addr_ack_in,
  input  wire logic         dside_slave_width_in,
  input  wire logic         dside_wr_data_ack_in
);
  logic [31:0] stage [16];
  logic [31:0] wbuf [16];
  logic [2:0]  widx = 3'h0;
  int          wexp, wgot, stalls;
  // past the last beat the bus shows spare words, not stale data
  assign dside_wr_data_bus = {wbuf[{widx, 1'b0}], wbuf[{widx, 1'b1}]};
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wgot <= 0;
      widx <= 3'h0;
    end else if (dside_wr_data_ack_in) begin
      wgot <= wgot + 1;
      widx <= widx + 3'h1;
    end
  end
  // request and abort low through reset
  always @(negedge rst_b) begin
    {dside_req_out, dside_abort_out} = 2'b00;
    wexp = 0;
  end
  task automatic put(input logic r, l, input logic [31:0] a,
                     input logic [7:0] be, input logic [5:0] ap);
    {dside_read_not_write, dside_line_size_sel, dside_addr_out} = {r, l, a};
    {dside_cacheable_attr, dside_write_through_attr, dside_user_attr,
     dside_guarded_attr, dside_req_priority, dside_byte_enables} = {ap, be};
  endtask
  initial begin
    put(1'b0, 1'b0, 32'h0, 8'h0, 6'h0);
    wbuf = '{default: 32'h0};
    {dside_req_out, dside_abort_out} = 2'b00;
  end
  task automatic issue(input logic r, l, input logic [31:0] a,
                       input logic [7:0] be, input logic [5:0] ap);
    int n;
    // write waits two cycles past the last write beat
    if (!r) begin
      for (n = 0; n < 300 && wgot != wexp; n++) @(posedge clk);
      stalls += (n == 300);
      repeat (2) @(posedge clk);
      wbuf = stage;
      widx = 3'h0;
    end
    // request low a full cycle between requests
    @(posedge clk);
    #2;
    put(r, l, a, be, ap);
    dside_req_out = 1'b1;
    // request held unchanged until ack seen
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if (dside_addr_ack_in) break;
    end
    stalls += (n == 300);
    if (!r) wexp += l ? (dside_slave_width_in ? 4 : 8) : 1;
    #2;
    dside_req_out = 1'b0;
    put(~r, ~l, ~a, ~be, ~ap);
  endtask
  // abort with the request, dropped next cycle
  task automatic abort_req(input logic [31:0] a);
    @(posedge clk);
    #2;
    put(1'b1, 1'b0, a, 8'hf0, 6'h0);
    {dside_req_out, dside_abort_out} = 2'b11;
    @(posedge clk);
    #2;
    {dside_req_out, dside_abort_out} = 2'b00;
  endtask
endmodule // dsb_port_model

// File: tb.sv
// self-checking bench for the data-side bus slave
`timescale 1ns/100ps
module tb;
  import dsb_pkg::*;
  typedef struct packed {
    logic rd; logic [2:0] idx; logic [63:0] d, m; logic e, f;
  } dsb_note_t;
  logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  logic dside_req_out, dside_read_not_write, dside_line_size_sel;
  logic dside_cacheable_attr, dside_write_through_attr, dside_user_attr;
  logic dside_guarded_attr, dside_abort_out, dside_addr_ack_in;
  logic dside_slave_width_in, dside_rd_data_ack_in, dside_wr_data_ack_in;
  logic dside_slave_busy_in, dside_slave_err_in;
  logic [3:0] last_attr_q, nib;
  logic [ADDR_W-1:0] dside_addr_out, la, a;
  logic [BE_W-1:0] dside_byte_enables;
  logic [PRIO_W-1:0] dside_req_priority;
  logic [DATA_W-1:0] dside_wr_data_bus, dside_rd_data_bus;
  logic [WIDX_W-1:0] dside_rd_word_index;
  logic [31:0] mem [256];
  logic [3:0] nibs [5] = '{4'hf, 4'hc, 4'h7, 4'h1, 4'h6};
  dsb_note_t notes [$];
  int failures, checks_done, seed = 11498;
  dsb_slave dsb_slave_i (.*);
  dsb_port_model dsb_port_model_i (.*);
  always #12.5 clk = ~clk;
  task automatic check(input string s, input logic [63:0] v, x);
    checks_done++;
    if (v !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, x, v);
    end
  endtask
  task automatic complete_run;
    failures += dsb_port_model_i.stalls;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset;
    #2 rst_b = 1'b0;
    notes.delete();
    repeat (4) @(posedge clk);
    check("quiet", {dside_addr_ack_in, dside_slave_busy_in, dside_slave_err_in}, 0);
    #2 rst_b = 1'b1;
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 300 && (notes.size() || dside_slave_busy_in); n++) @(posedge clk);
    if (n == 300) failures++;
    if (n == 300) complete_run;
  endtask
  // f marks the last beat, so this counts whole read requests
  function automatic int reads_owed;
    int c = 0;
    foreach (notes[j]) c += notes[j].rd && notes[j].f;
    return c;
  endfunction
  task automatic xfer(input logic r, l, input logic [31:0] a, input logic [7:0] be);
    logic [5:0] ap;
    logic [1:0] dw;
    logic [63:0] m;
    logic [7:0] w;
    logic [3:0] bs;
    logic e;
    logic fin;
    int n;
    for (n = 0; n < 300 && r && reads_owed() > 1; n++) @(posedge clk);
    if (n == 300) begin
      failures++;
      complete_run;
    end
    ap = 6'($random(seed));
    e = |a[31:10];
    w = a[9:2];
    bs = a[2] ? be[3:0] : be[7:4];
    m = a[2] ? 64'h0000_0000_ffff_ffff : 64'hffff_ffff_0000_0000;
    for (int k = 0; k < 16; k++) dsb_port_model_i.stage[k] = $random(seed);
    for (int k = 0; k < 8; k++) begin
      dw = a[4:3] + k[1:0];
      fin = (k == (l ? 3 : 0));
      if (k < (l ? 4 : 1)) begin
        if (!r) notes.push_back('{1'b0, 3'h0, 64'h0, 64'h0, e, fin});
        else if (l) notes.push_back('{1'b1, {dw, 1'b0}, e ? 64'h0 :
          {mem[{w[7:3], dw, 1'b0}], mem[{w[7:3], dw, 1'b1}]}, '1, e, fin});
        else notes.push_back('{1'b1, 3'h0,
          e ? 64'h0 : {2{mem[w]}} & m, m, e, fin});
      end
      if (!r && !e && l) mem[{w[7:3], k[2:0]}] = dsb_port_model_i.stage[k];
      if (!r && !e && !l && k < 4 && bs[3 - k])
        mem[w][31 - 8 * k -: 8] = dsb_port_model_i.stage[a[2]][31 - 8 * k -: 8];
    end
    dsb_port_model_i.issue(r, l, a, be, ap);
    if (dsb_port_model_i.stalls != 0) complete_run;
    @(posedge clk);
    #2;
    check("attributes", last_attr_q, {ap[5], ap[5] & ap[4], ap[3:2]});
  endtask
  always @(posedge clk) begin : watch
    dsb_note_t n;
    if (rst_b && (dside_rd_data_ack_in || dside_wr_data_ack_in)) begin
      check("beat due", notes.size() != 0, 1'b1);
      n = notes.size() ? notes.pop_front() : '0;
      check("beat kind", dside_rd_data_ack_in, n.rd);
      check("error flag", dside_slave_err_in, n.e);
      check("read data", dside_rd_data_bus & n.m, n.d);
      if (&n.m) check("word index", dside_rd_word_index, n.idx);
    end
  end
  initial begin
    do_reset;
    la = {$random(seed)} & 32'h3e0;
    xfer(1'b0, 1'b1, la | 32'h14, 8'h0);
    for (int d = 0; d < 4; d++) xfer(1'b1, 1'b1, la + 8 * d, 8'h0);
    wait_idle;
    $display("test line wrap done");
    for (int i = 0; i < 32; i++) begin
      a = la | ({$random(seed)} & 32'h1c) | ((i == 21 || i == 22) ? 32'h400 : 0);
      nib = nibs[i % 5];
      xfer(i[0], i[1], a, a[2] ? {4'h0, nib} : {nib, 4'h0});
    end
    wait_idle;
    $display("test mixed traffic done");
    dsb_port_model_i.abort_req(la);
    @(posedge clk);
    check("ack after abort", dside_addr_ack_in, 1'b0);
    do_reset;
    xfer(1'b0, 1'b1, la, 8'h0);
    xfer(1'b1, 1'b1, la | 32'h18, 8'h0);
    wait_idle;
    $display("test abort and reset done");
    complete_run;
  end
endmodule // tb
